/* File: hdl/csq_pkg.sv */
// Constants and types shared by the core regulator soft-start sequencer.
// Assumes one 250 MHz clock; faults arrive as comparator levels, output sense as a 9-bit value.
package csq_pkg;

   // ==========================================================
   // Clock and fixed delays
   localparam int unsigned CLK_PERIOD_NS    = 4;
   localparam int unsigned INIT_DELAY_NS    = 1360000;  // Fixed first delay
   localparam int unsigned BOOT_HOLD_NS     = 85000;    // Fixed boot-level hold
   localparam int unsigned CODE_VALID_NS    = 500;      // Least code stability
   localparam int unsigned READY_DELAY_NS   = 85000;    // Ready release delay
   // Least times round up to whole cycles
   localparam int unsigned INIT_DELAY_CYC   = (INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BOOT_HOLD_CYC    = (BOOT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CODE_VALID_CYC   = (CODE_VALID_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned READY_DELAY_CYC  = (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // Reference ramp
   localparam int unsigned DAC_STEP_UV      = 6250;     // 6.25 mV per step
   localparam int unsigned BOOT_UV          = 1100000;  // 1.1 V boot level
   localparam logic [8:0]  BOOT_STEPS       = 9'(BOOT_UV / DAC_STEP_UV);
   // Step period in us is R(kohm)/25, so cycles per kohm = 1000/25/period
   localparam int unsigned RATE_DIVISOR     = 25;
   localparam int unsigned STEP_CYC_PER_K   = 1000 / RATE_DIVISOR / CLK_PERIOD_NS;
   // Code to steps: steps = CODE_TOP_STEPS - code for codes 02h..FDh
   localparam logic [8:0]  CODE_TOP_STEPS   = 9'h104;
   localparam logic [7:0]  OFF_CODE_A       = 8'h00;
   localparam logic [7:0]  OFF_CODE_B       = 8'h01;
   localparam logic [7:0]  OFF_CODE_C       = 8'hFE;
   localparam logic [7:0]  OFF_CODE_D       = 8'hFF;

   // ==========================================================
   // Protection
   localparam logic [12:0] HICCUP_SW_CYCLES = 13'h1000;  // 4096 switching periods
   localparam logic [3:0]  UV_LOW_TENTHS    = 4'h5;      // Trip below 50 %
   localparam logic [3:0]  UV_HIGH_TENTHS   = 4'h6;      // Recover at 60 %

   // ==========================================================
   // Types
   typedef enum logic [3:0] {
      S_SHUT    = 4'h0,
      S_DLY1    = 4'h1,
      S_RAMP1   = 4'h2,
      S_HOLD    = 4'h3,
      S_RAMP2   = 4'h4,
      S_RDYDLY  = 4'h5,
      S_RUN     = 4'h6,
      S_OCWAIT  = 4'h7,
      S_LATCHED = 4'h8
   } csq_state_t;

   // Comparator levels from the analog front end
   typedef struct packed {
      logic ov_trip;      // Output above overvoltage trip
      logic ocp_clamp;    // Average current monitor at its clamp level
   } csq_fault_t;

endpackage

/* File: hdl/csq_step_timer.sv */
// Soft-start oscillator: one-cycle step pulse every R(kohm) * 10 clocks.
// Assumes the rate resistor value is static while a ramp runs.
`timescale 1ns/10ps
`default_nettype none
module csq_step_timer (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       run_i,
   input  wire logic [9:0] rate_kohm_i,
   output logic            step_o
);
   logic [13:0] cnt_q;
   logic [13:0] limit;

   // ==========================================================
   // Period from the rate resistor; zero ohms steps every cycle
   assign limit = (rate_kohm_i == 10'h000) ? 14'h0000 :
                  14'(rate_kohm_i * csq_pkg::STEP_CYC_PER_K - 1);

   // Free count restarts whenever the ramp is idle, so a ramp's first step
   // is a full period after its start
   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i || cnt_q >= limit) begin
         cnt_q <= 14'h0000;
      end else begin
         cnt_q <= cnt_q + 14'h0001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         step_o <= 1'b0;
      end else begin
         step_o <= run_i && (cnt_q >= limit);
      end
   end
endmodule
`default_nettype wire

/* File: hdl/csq_sequencer.sv */
// Core regulator soft-start sequencer: shutdown gate, two-ramp soft-start,
// ready output and fault handling. Comparators and pins arrive synchronous.
`timescale 1ns/10ps
`default_nettype none
module csq_sequencer #(
   parameter int unsigned INIT_DELAY_CYC  = csq_pkg::INIT_DELAY_CYC,
   parameter int unsigned BOOT_HOLD_CYC   = csq_pkg::BOOT_HOLD_CYC,
   parameter int unsigned READY_DELAY_CYC = csq_pkg::READY_DELAY_CYC
) (
   input  wire logic               MCLK_I,
   input  wire logic               RST_I,
   input  wire logic               BIAS_POR_OK_I,
   input  wire logic               POWER_RAIL_ENABLE_I,
   input  wire logic               TERMINATION_RAIL_ENABLE_I,
   input  wire logic [7:0]         VOLTAGE_CODE_I,
   input  wire logic signed [7:0]  OFFSET_PROGRAM_PIN_I,
   input  wire logic [9:0]         RATE_RES_KOHM_I,
   input  wire logic [11:0]        SW_PERIOD_CYC_I,
   input  wire logic [8:0]         OUTPUT_SENSE_I,
   input  wire csq_pkg::csq_fault_t FAULT_I,
   input  wire logic               LIGHT_LOAD_REQUEST_N_I,
   input  wire logic [5:0]         PHASE_MOD_I,
   output logic [5:0]              PHASE_PWM_O,
   output logic [5:0]              PHASE_PWM_OE_O,
   output logic [8:0]              REF_DAC_O,
   output logic                    REGULATOR_READY_OUT_O,
   output logic                    REGULATOR_READY_OUT_OE_O,
   output logic                    LIGHT_LOAD_MODE_O,
   output logic [3:0]              STATE_O
);
   csq_pkg::csq_state_t st_q;
   csq_pkg::csq_state_t st_d;
   logic [19:0]         cnt_q;
   logic [7:0]          code_hist_q;
   logic [7:0]          stab_q;
   logic [8:0]          ref_q;
   logic [8:0]          target_q;
   logic [8:0]          code_steps;
   logic [9:0]          target_calc;
   logic [11:0]         sw_cnt_q;
   logic [12:0]         hiccup_q;
   logic                ov_lat_q;
   logic                uv_q;
   logic                en_ok;
   logic                active;
   logic                ramping;
   logic                step;
   logic                code_off;
   logic                code_ready;
   logic                rdy_d;
   logic [12:0]         sense_x10;
   logic [12:0]         tgt_lo;
   logic [12:0]         tgt_hi;

   // ==========================================================
   // Enable conditions and decoded values
   assign en_ok      = BIAS_POR_OK_I && POWER_RAIL_ENABLE_I && TERMINATION_RAIL_ENABLE_I;
   assign active     = (st_q == csq_pkg::S_RAMP1) || (st_q == csq_pkg::S_HOLD) ||
                       (st_q == csq_pkg::S_RAMP2) || (st_q == csq_pkg::S_RDYDLY) ||
                       (st_q == csq_pkg::S_RUN);
   assign ramping    = (st_q == csq_pkg::S_RAMP1) || (st_q == csq_pkg::S_RAMP2);
   assign code_off   = (VOLTAGE_CODE_I == csq_pkg::OFF_CODE_A) || (VOLTAGE_CODE_I == csq_pkg::OFF_CODE_B) ||
                       (VOLTAGE_CODE_I == csq_pkg::OFF_CODE_C) || (VOLTAGE_CODE_I == csq_pkg::OFF_CODE_D);
   assign code_steps = csq_pkg::CODE_TOP_STEPS - {1'b0, VOLTAGE_CODE_I};
   // Offset subtracts from the code's steps; clamp at zero rather than wrap
   assign target_calc = 10'({1'b0, code_steps} - 10'(signed'(OFFSET_PROGRAM_PIN_I)));
   assign code_ready  = (stab_q >= 8'(csq_pkg::CODE_VALID_CYC));

   // ==========================================================
   // Soft-start oscillator; its period follows the rate resistor
   csq_step_timer u_step (
      .clk_i       (MCLK_I),
      .rst_i       (RST_I),
      .run_i       (ramping),
      .rate_kohm_i (RATE_RES_KOHM_I),
      .step_o      (step)
   );

   // ==========================================================
   // Sequencer next state; loss of any enable wins over everything
   always_comb begin
      st_d = st_q;
      case (st_q)
         csq_pkg::S_SHUT: begin
            if (en_ok && !ov_lat_q) begin
               st_d = csq_pkg::S_DLY1;
            end
         end
         csq_pkg::S_DLY1: begin
            if (cnt_q >= 20'(INIT_DELAY_CYC - 1)) begin
               st_d = csq_pkg::S_RAMP1;
            end
         end
         csq_pkg::S_RAMP1: begin
            if (step && ref_q >= csq_pkg::BOOT_STEPS - 9'h001) begin
               st_d = csq_pkg::S_HOLD;
            end
         end
         csq_pkg::S_HOLD: begin
            if (cnt_q >= 20'(BOOT_HOLD_CYC - 1) && code_ready) begin
               st_d = code_off ? csq_pkg::S_LATCHED : csq_pkg::S_RAMP2;
            end
         end
         csq_pkg::S_RAMP2: begin
            if (ref_q == target_q) begin
               st_d = csq_pkg::S_RDYDLY;
            end
         end
         csq_pkg::S_RDYDLY: begin
            if (cnt_q >= 20'(READY_DELAY_CYC - 1)) begin
               st_d = csq_pkg::S_RUN;
            end
         end
         csq_pkg::S_RUN: begin
            st_d = csq_pkg::S_RUN;
         end
         csq_pkg::S_OCWAIT: begin
            if (hiccup_q >= csq_pkg::HICCUP_SW_CYCLES) begin
               st_d = csq_pkg::S_DLY1;
            end
         end
         csq_pkg::S_LATCHED: begin
            st_d = csq_pkg::S_LATCHED;
         end
         default: begin
            st_d = csq_pkg::S_SHUT;
         end
      endcase
      if (active && FAULT_I.ocp_clamp) begin
         st_d = csq_pkg::S_OCWAIT;
      end
      if (ov_lat_q || (BIAS_POR_OK_I && FAULT_I.ov_trip)) begin
         st_d = en_ok ? csq_pkg::S_LATCHED : csq_pkg::S_SHUT;
      end
      if (!en_ok) begin
         st_d = csq_pkg::S_SHUT;
      end
   end

   // State register
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         st_q <= csq_pkg::S_SHUT;
      end else begin
         st_q <= st_d;
      end
   end

   // Shared delay counter, cleared on every state change
   always_ff @(posedge MCLK_I) begin
      if (RST_I || st_d != st_q) begin
         cnt_q <= 20'h00000;
      end else if (cnt_q != 20'hFFFFF) begin
         cnt_q <= cnt_q + 20'h00001;
      end
   end

   // Code must hold still for the validation time before it is taken
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         code_hist_q <= 8'h00;
         stab_q      <= 8'h00;
      end else begin
         code_hist_q <= VOLTAGE_CODE_I;
         if (VOLTAGE_CODE_I != code_hist_q) begin
            stab_q <= 8'h00;
         end else if (!code_ready) begin
            stab_q <= stab_q + 8'h01;
         end
      end
   end

   // ==========================================================
   // Reference ramp: one step per oscillator pulse, both ramps
   always_ff @(posedge MCLK_I) begin
      if (RST_I || st_q == csq_pkg::S_SHUT || st_q == csq_pkg::S_DLY1 ||
          st_q == csq_pkg::S_OCWAIT || st_q == csq_pkg::S_LATCHED) begin
         ref_q <= 9'h000;
      end else if (step && st_q == csq_pkg::S_RAMP1 && ref_q < csq_pkg::BOOT_STEPS) begin
         ref_q <= ref_q + 9'h001;
      end else if (step && st_q == csq_pkg::S_RAMP2 && ref_q < target_q) begin
         ref_q <= ref_q + 9'h001;
      end else if (step && st_q == csq_pkg::S_RAMP2 && ref_q > target_q) begin
         ref_q <= ref_q - 9'h001;
      end
   end

   // Target sampled once, at the end of the hold
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         target_q <= 9'h000;
      end else if (st_q == csq_pkg::S_HOLD && st_d == csq_pkg::S_RAMP2) begin
         target_q <= target_calc[9] ? 9'h000 : target_calc[8:0];
      end
   end

   // ==========================================================
   // Hiccup wait: counts programmed switching periods
   always_ff @(posedge MCLK_I) begin
      if (RST_I || st_q != csq_pkg::S_OCWAIT) begin
         sw_cnt_q <= 12'h000;
         hiccup_q <= 13'h0000;
      end else if (sw_cnt_q >= SW_PERIOD_CYC_I - 12'h001) begin
         sw_cnt_q <= 12'h000;
         hiccup_q <= hiccup_q + 13'h0001;
      end else begin
         sw_cnt_q <= sw_cnt_q + 12'h001;
      end
   end

   // Overvoltage latch; only dropping bias or an enable clears it,
   // a changed code alone does not
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         ov_lat_q <= 1'b0;
      end else if (BIAS_POR_OK_I && FAULT_I.ov_trip) begin
         ov_lat_q <= 1'b1;
      end else if (!en_ok) begin
         ov_lat_q <= 1'b0;
      end
   end

   // ==========================================================
   // Undervoltage with hysteresis, in tenths of the requested level
   assign sense_x10 = 13'(OUTPUT_SENSE_I) * 13'h000A;
   assign tgt_lo    = 13'(target_q) * 13'(csq_pkg::UV_LOW_TENTHS);
   assign tgt_hi    = 13'(target_q) * 13'(csq_pkg::UV_HIGH_TENTHS);

   always_ff @(posedge MCLK_I) begin
      if (RST_I || st_q != csq_pkg::S_RUN) begin
         uv_q <= 1'b0;
      end else if (sense_x10 < tgt_lo) begin
         uv_q <= 1'b1;
      end else if (sense_x10 >= tgt_hi) begin
         uv_q <= 1'b0;
      end
   end

   // ==========================================================
   // Ready pin: open drain, driven low unless running and fault free
   assign rdy_d = (st_q == csq_pkg::S_RUN) && !uv_q && !ov_lat_q &&
                  !FAULT_I.ocp_clamp && en_ok;

   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         REGULATOR_READY_OUT_O    <= 1'b0;
         REGULATOR_READY_OUT_OE_O <= 1'b1;
      end else begin
         REGULATOR_READY_OUT_O    <= 1'b0;
         REGULATOR_READY_OUT_OE_O <= !rdy_d;
      end
   end

   // Light load only honoured once ready is released
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         LIGHT_LOAD_MODE_O <= 1'b0;
      end else begin
         LIGHT_LOAD_MODE_O <= rdy_d && !LIGHT_LOAD_REQUEST_N_I;
      end
   end

   // ==========================================================
   // Phase outputs: an overvoltage pulls them low, idle states float them
   // so the drivers keep both switches off
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         PHASE_PWM_O    <= 6'h00;
         PHASE_PWM_OE_O <= 6'h00;
      end else if (BIAS_POR_OK_I && FAULT_I.ov_trip) begin
         PHASE_PWM_O    <= 6'h00;
         PHASE_PWM_OE_O <= 6'h3F;
      end else if (active && !ov_lat_q && !(FAULT_I.ocp_clamp)) begin
         PHASE_PWM_O    <= PHASE_MOD_I;
         PHASE_PWM_OE_O <= 6'h3F;
      end else begin
         PHASE_PWM_O    <= 6'h00;
         PHASE_PWM_OE_O <= 6'h00;
      end
   end

   // Reference and state visibility
   always_ff @(posedge MCLK_I) begin
      if (RST_I) begin
         REF_DAC_O <= 9'h000;
         STATE_O   <= 4'h0;
      end else begin
         REF_DAC_O <= ref_q;
         STATE_O   <= st_q;
      end
   end

   // ==========================================================
   // Checks
   shut_float_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (st_q == csq_pkg::S_SHUT && !FAULT_I.ov_trip) |=> (PHASE_PWM_OE_O == 6'h00))
      else $error("phase outputs driven in shutdown");
   bias_gate_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      !BIAS_POR_OK_I |=> st_q == csq_pkg::S_SHUT)
      else $error("left shutdown without bias reset");
   enable_gate_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (!POWER_RAIL_ENABLE_I || !TERMINATION_RAIL_ENABLE_I) |=> st_q == csq_pkg::S_SHUT)
      else $error("left shutdown without both enables");
   ramp_step_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (ramping && !step && st_d == st_q) |=> $stable(ref_q))
      else $error("reference moved without oscillator step");
   boot_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (st_q == csq_pkg::S_HOLD) |-> (ref_q == csq_pkg::BOOT_STEPS))
      else $error("hold not at boot level");
   light_load_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      REGULATOR_READY_OUT_OE_O |-> !LIGHT_LOAD_MODE_O)
      else $error("light load honoured before ready");
   ready_low_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (st_q != csq_pkg::S_RUN) |=> REGULATOR_READY_OUT_OE_O)
      else $error("ready released outside run");
   ocp_float_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (active && FAULT_I.ocp_clamp && en_ok && !ov_lat_q && !FAULT_I.ov_trip)
      |=> (st_q == csq_pkg::S_OCWAIT) && (PHASE_PWM_OE_O == 6'h00))
      else $error("overcurrent did not float outputs");
   ov_hold_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (ov_lat_q && en_ok) |=> ov_lat_q && (st_q != csq_pkg::S_RUN))
      else $error("overvoltage latch released while enabled");
   off_code_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
      (st_q == csq_pkg::S_LATCHED && en_ok) |=> st_q == csq_pkg::S_LATCHED)
      else $error("off code latch left while enabled");
endmodule
`default_nettype wire

/* File: dv/csq_partner.sv */
// Far-side model: driver bias gating of the rail enable, and a regulator
// whose sensed output follows the reference scaled by a load factor.
`timescale 1ns/10ps
`default_nettype none
module csq_partner (
   input  wire logic       clk_i,
   input  wire logic       driver_bias_ok_i,
   input  wire logic       enable_req_i,
   input  wire logic [8:0] ref_i,
   input  wire logic [3:0] sense_tenths_i,
   output logic            power_rail_enable_o,
   output logic [8:0]      output_sense_o
);
   // ==========================================================
   // Enable withheld until the drivers have their own bias
   always_ff @(negedge clk_i) power_rail_enable_o <= enable_req_i & driver_bias_ok_i;
   // Output tracks the reference; a factor below ten mimics a sagging rail
   always_ff @(negedge clk_i) output_sense_o <= 9'((18'(ref_i) * sense_tenths_i) / 10);
endmodule
`default_nettype wire

/* File: dv/csq_sequencer_bench.sv */
// Self-checking bench for the soft-start sequencer.
// Assumes the partner model and shortened delay parameters.
`timescale 1ns/10ps
`default_nettype none
module csq_sequencer_bench;
   localparam int INIT = 20;
   localparam int HOLD = 10;
   localparam int RDY  = 10;
   logic                clk, rst, bias, en_req, drv_ok, term, lln, pwr_en, rdy, rdy_oe, llm;
   logic [7:0]          code;
   logic [9:0]          rate;
   logic [3:0]          tenths, st;
   logic [8:0]          sense, dac, prev;
   logic [5:0]          pwm, oe;
   csq_pkg::csq_fault_t fault;
   int                  error_cnt = 0, comparisons = 0, cyc;
   logic [7:0]          offs [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};

   csq_sequencer #(.INIT_DELAY_CYC(INIT), .BOOT_HOLD_CYC(HOLD), .READY_DELAY_CYC(RDY)) u_dut (
      .MCLK_I(clk), .RST_I(rst), .BIAS_POR_OK_I(bias), .POWER_RAIL_ENABLE_I(pwr_en),
      .TERMINATION_RAIL_ENABLE_I(term), .VOLTAGE_CODE_I(code), .OFFSET_PROGRAM_PIN_I(8'sh04),
      .RATE_RES_KOHM_I(rate), .SW_PERIOD_CYC_I(12'h001), .OUTPUT_SENSE_I(sense), .FAULT_I(fault),
      .LIGHT_LOAD_REQUEST_N_I(lln), .PHASE_MOD_I(6'h2A), .PHASE_PWM_O(pwm), .PHASE_PWM_OE_O(oe),
      .REF_DAC_O(dac), .REGULATOR_READY_OUT_O(rdy), .REGULATOR_READY_OUT_OE_O(rdy_oe),
      .LIGHT_LOAD_MODE_O(llm), .STATE_O(st));
   csq_partner u_partner (.clk_i(clk), .driver_bias_ok_i(drv_ok), .enable_req_i(en_req),
      .ref_i(dac), .sense_tenths_i(tenths), .power_rail_enable_o(pwr_en), .output_sense_o(sense));

   // ==========================================================
   // Clock, closing task and compares
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task automatic end_of_test;
      $display("Compares %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk_val(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_span(input int got, input int lo, input int hi);
      comparisons++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: span %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   // Bounded wait for a state code; cyc keeps the cycles spent
   task automatic wait_st(input logic [3:0] s);
      cyc = 0;
      while (st !== s && cyc < 6000) begin
         @(negedge clk);
         cyc++;
      end
      chk_val(9'(st), 9'(s));
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_shut;
      chk_val(9'(oe), 9'h000);
      chk_val(9'(rdy_oe), 9'h001);
      chk_val(9'(rdy), 9'h000);
      // Each hold-off leaves exactly one condition missing
      term = 1'b1;
      repeat (30) @(negedge clk);
      chk_val(9'(st), 9'h000);
      drv_ok = 1'b1;
      term = 1'b0;
      repeat (30) @(negedge clk);
      chk_val(9'(st), 9'h000);
      term = 1'b1;
      bias = 1'b0;
      repeat (30) @(negedge clk);
      chk_val(9'(st), 9'h000);
      $display("shutdown test done");
   endtask
   task automatic t_start;
      bias = 1'b1;
      wait_st(4'h1);
      wait_st(4'h2);
      chk_span(cyc, INIT - 1, INIT + 1);
      prev = dac;
      wait (dac !== prev);
      prev = dac;
      @(negedge clk);
      cyc = 0;
      while (dac === prev && cyc < 50) begin
         @(negedge clk);
         cyc++;
      end
      chk_span(cyc, 10, 10);
      chk_val(dac - prev, 9'h001);
      wait_st(4'h3);
      chk_val(dac, 9'h0B0);
      wait_st(4'h4);
      chk_span(cyc, HOLD - 1, HOLD + 2);
      wait_st(4'h5);
      chk_val(dac, 9'h0A0);
      chk_val(9'({llm, rdy_oe}), 9'h001);
      wait_st(4'h6);
      chk_span(cyc, RDY - 1, RDY + 1);
      repeat (2) @(negedge clk);
      chk_val(9'({llm, rdy_oe}), 9'h002);
      chk_val(9'(pwm), 9'h02A);
      // Light load follows the request pin once ready is released
      lln = 1'b1;
      repeat (2) @(negedge clk);
      chk_val(9'(llm), 9'h000);
      lln = 1'b0;
      repeat (2) @(negedge clk);
      $display("soft-start test done");
   endtask
   task automatic t_uv;
      foreach (offs[i]) begin
         tenths = (i == 0) ? 4'h4 : (i == 1) ? 4'h5 : (i == 2) ? 4'h6 : 4'hA;
         repeat (5) @(negedge clk);
         chk_val(9'(rdy_oe), (i < 2) ? 9'h001 : 9'h000);
      end
      $display("undervoltage test done");
   endtask
   task automatic t_ocp;
      rate = 10'h000;
      fault.ocp_clamp = 1'b1;
      repeat (3) @(negedge clk);
      chk_val(9'(oe), 9'h000);
      chk_val(9'({rdy_oe, st}), 9'h017);
      fault.ocp_clamp = 1'b0;
      wait_st(4'h1);
      chk_span(cyc, 4092, 4099);
      wait_st(4'h6);
      $display("overcurrent test done");
   endtask
   task automatic t_off;
      foreach (offs[i]) begin
         term = 1'b0;
         repeat (3) @(negedge clk);
         chk_val(9'({rdy_oe, st}), 9'h010);
         code = offs[i];
         term = 1'b1;
         wait_st(4'h8);
         chk_val(9'({oe, rdy_oe}), 9'h001);
      end
      code = 8'h60;
      repeat (200) @(negedge clk);
      chk_val(9'(st), 9'h008);
      term = 1'b0;
      @(negedge clk);
      term = 1'b1;
      wait_st(4'h1);
      wait_st(4'h6);
      $display("off code test done");
   endtask
   task automatic t_ov;
      fault.ov_trip = 1'b1;
      repeat (3) @(negedge clk);
      chk_val(9'(pwm), 9'h000);
      chk_val(9'(oe), 9'h03F);
      chk_val(9'(st), 9'h008);
      chk_val(9'(rdy_oe), 9'h001);
      fault.ov_trip = 1'b0;
      code = 8'h50;
      repeat (200) @(negedge clk);
      chk_val(9'(oe), 9'h000);
      chk_val(9'(st), 9'h008);
      bias = 1'b0;
      @(negedge clk);
      bias = 1'b1;
      wait_st(4'h1);
      $display("overvoltage test done");
   endtask

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      rst = 1'b1;
      bias = 1'b1;
      en_req = 1'b1;
      drv_ok = 1'b0;
      term = 1'b0;
      lln = 1'b0;
      code = 8'h60;
      rate = 10'h001;
      tenths = 4'hA;
      fault = '0;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_shut();
      t_start();
      t_uv();
      t_ocp();
      t_off();
      t_ov();
      end_of_test();
   end
   // Whole run needs about 8000 cycles
   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
`default_nettype wire
